// [rtl/hbd_top.sv]
// host bus transaction decoder: in-order queue and response generator
module hbd_top
    import hbd_pkg::*;
#(
    parameter int DEPTH = IOQ_DEPTH
)
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // request phase
    input  wire logic        reqValid,
    input  wire logic [4:0]  request_code_phase_a,
    input  wire logic [4:0]  request_code_phase_b,
    input  wire logic [31:0] reqAddr,
    input  wire logic [7:0]  byte_enable_lines,
    input  wire logic        reqLocked,
    output logic             reqReady,
    // address decode inputs
    input  wire logic        memIsDram,
    input  wire logic        memIsGfx,
    input  wire logic        ioIsCfg,
    input  wire logic        ioIsGfx,
    // snoop and target state
    input  wire logic        snoopHitM,
    input  wire logic        hubBusy,
    input  wire logic        deferEnable,
    // target dispatch
    output logic             dispValid,
    output hbd_target_e      dispTarget,
    output hbd_req_s         dispReq,
    output logic [5:0]       dispBytes,
    output logic             dispDropData,
    input  wire logic        dispDone,
    // deferred completion
    input  wire logic        deferDone,
    output logic             deferReplyValid,
    output logic [4:0]       deferReplyCode,
    input  wire logic        deferReplyTaken,
    // response phase
    output logic             response_code_bit2,
    output logic             response_code_bit1,
    output logic             response_code_bit0
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RESP = 3'b100
    } hbd_state_e;

    localparam int PW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////
    // in-order queue
    hbd_req_s       qReq_reg [DEPTH];
    logic [PW-1:0]  wrPtr_reg;
    logic [PW-1:0]  rdPtr_reg;
    logic [PW:0]    count_reg;
    logic           push;
    logic           pop;
    hbd_req_s       inReq;
    hbd_req_s       headReq;
    hbd_dec_s       headDec;
    hbd_state_e     state_reg;
    hbd_state_e     state_next;
    logic [2:0]     rsp_reg;
    logic [2:0]     rsp_next;
    logic           deferPend_reg;

    assign inReq = '{reqA: request_code_phase_a, reqB: request_code_phase_b,
                     addr: reqAddr, byteEn: byte_enable_lines, locked: reqLocked};
    assign reqReady = (count_reg < (PW+1)'(DEPTH));
    assign push = reqValid && reqReady;
    assign pop = (state_reg == ST_RESP);
    assign headReq = qReq_reg[rdPtr_reg];

    always_ff @(posedge clk) begin
        if (push) begin
            qReq_reg[wrPtr_reg] <= inReq;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    hbd_decode u_decode (
        .req       (headReq),
        .memIsDram (memIsDram),
        .memIsGfx  (memIsGfx),
        .ioIsCfg   (ioIsCfg),
        .ioIsGfx   (ioIsGfx),
        .dec       (headDec)
    );

    ////////////////////////////////////////////////////////////////////
    // response selection
    logic headBusy;
    logic mayRetry;
    logic mayDefer;
    logic needTarget;

    assign headBusy = (count_reg != '0) && (state_reg == ST_IDLE);
    // retry: hub-directed, or locked dram read, never a writeback
    assign mayRetry = !headDec.noRetry && hubBusy
                      && ((headDec.target == TGT_HUB)
                          || (headDec.target == TGT_DRAM && headReq.locked && headDec.isRead));
    assign mayDefer = deferEnable && headDec.deferOk && !deferPend_reg;
    assign needTarget = (headDec.target == TGT_DRAM) || (headDec.target == TGT_HUB)
                        || (headDec.target == TGT_GFX) || (headDec.target == TGT_SPEC)
                        || (headDec.target == TGT_CFG);

    always_comb begin
        state_next = state_reg;
        rsp_next = RSP_IDLE;
        unique case (state_reg)
            ST_IDLE: begin
                if (headBusy) begin
                    if (snoopHitM) begin
                        state_next = ST_RESP;
                        rsp_next = RSP_IWB;
                    end else if (mayRetry) begin
                        state_next = ST_RESP;
                        rsp_next = RSP_RETRY;
                    end else if (mayDefer) begin
                        state_next = ST_RESP;
                        rsp_next = RSP_DEFER;
                    end else if (needTarget) begin
                        state_next = ST_WAIT;
                    end else begin
                        state_next = ST_RESP;
                        rsp_next = RSP_NODATA;
                    end
                end
            end
            ST_WAIT: begin
                if (dispDone) begin
                    state_next = ST_RESP;
                    if (headDec.isRead && !headDec.zeroLen) begin
                        rsp_next = RSP_NORMAL;
                    end else begin
                        rsp_next = RSP_NODATA;
                    end
                end
            end
            ST_RESP: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            rsp_reg <= RSP_IDLE;
        end else begin
            state_reg <= state_next;
            rsp_reg <= rsp_next;
        end
    end

    assign response_code_bit2 = rsp_reg[2];
    assign response_code_bit1 = rsp_reg[1];
    assign response_code_bit0 = rsp_reg[0];

    ////////////////////////////////////////////////////////////////////
    // dispatch to targets
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dispValid <= 1'b0;
            dispTarget <= TGT_NONE;
            dispReq <= '0;
            dispBytes <= '0;
            dispDropData <= 1'b0;
        end else begin
            dispValid <= (state_next == ST_WAIT) && (state_reg == ST_IDLE);
            if (state_reg == ST_IDLE) begin
                dispTarget <= headDec.target;
                dispReq <= headReq;
                dispBytes <= headDec.byteCount;
                dispDropData <= headDec.dropData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // deferred reply initiation
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            deferPend_reg <= 1'b0;
            deferReplyValid <= 1'b0;
        end else begin
            if (rsp_next == RSP_DEFER) begin
                deferPend_reg <= 1'b1;
            end else if (deferReplyValid && deferReplyTaken) begin
                deferPend_reg <= 1'b0;
            end
            if (deferPend_reg && deferDone && !deferReplyValid) begin
                deferReplyValid <= 1'b1;
            end else if (deferReplyTaken) begin
                deferReplyValid <= 1'b0;
            end
        end
    end

    assign deferReplyCode = REQ_DEFER_REPLY;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_queue_bound: assert property (@(posedge clk) disable iff (sys_rst)
        count_reg <= (PW+1)'(DEPTH))
        else $error("queue over depth");

    a_pop_order: assert property (@(posedge clk) disable iff (sys_rst)
        pop |=> rdPtr_reg == (($past(rdPtr_reg) == PW'(DEPTH-1)) ? '0
                              : $past(rdPtr_reg) + 1'b1))
        else $error("queue read out of order");

    a_no_bad_rsp: assert property (@(posedge clk) disable iff (sys_rst)
        rsp_reg != 3'h4 && rsp_reg != 3'h3)
        else $error("illegal response code");

    a_rsp_idle: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg != ST_RESP) |-> rsp_reg == RSP_IDLE)
        else $error("response outside response phase");

    a_wb_no_retry: assert property (@(posedge clk) disable iff (sys_rst)
        (headBusy && headReq.reqA == REQ_MEM_WB) |=> rsp_reg != RSP_RETRY)
        else $error("writeback was retried");

    a_wb_dram: assert property (@(posedge clk) disable iff (sys_rst)
        (headBusy && headReq.reqA == REQ_MEM_WB && !snoopHitM)
        |=> dispValid && dispTarget == TGT_DRAM)
        else $error("writeback not sent to dram");

    a_snoop_iwb: assert property (@(posedge clk) disable iff (sys_rst)
        (headBusy && snoopHitM) |=> rsp_reg == RSP_IWB)
        else $error("missing implicit writeback");

    a_read_data: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_WAIT && dispDone && headDec.isRead && !headDec.zeroLen)
        |=> rsp_reg == RSP_NORMAL)
        else $error("read without normal data");

    a_write_nodata: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_WAIT && dispDone && headDec.isWrite) |=> rsp_reg == RSP_NODATA)
        else $error("write without no data response");

    a_io_cfg_local: assert property (@(posedge clk) disable iff (sys_rst)
        (headBusy && ioIsCfg && (headReq.reqA == REQ_IO_RD || headReq.reqA == REQ_IO_WR)
         && !snoopHitM) |=> dispTarget != TGT_HUB)
        else $error("config io forwarded to hub");

    a_defer_reply: assert property (@(posedge clk) disable iff (sys_rst)
        (deferPend_reg && deferDone && !deferReplyValid) |=> deferReplyValid)
        else $error("deferred reply not raised");

    a_disp_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        dispValid |=> !dispValid)
        else $error("dispatch longer than one cycle");

    a_btm_drop: assert property (@(posedge clk) disable iff (sys_rst)
        (headBusy && headReq.reqA == REQ_BTM && headReq.reqB == 5'h00 && !snoopHitM)
        |=> rsp_reg == RSP_NODATA && !dispValid && dispDropData)
        else $error("branch trace data not dropped");

    a_io_hub: assert property (@(posedge clk) disable iff (sys_rst)
        (headBusy && (headReq.reqA == REQ_IO_RD || headReq.reqA == REQ_IO_WR)
         && !ioIsCfg && !ioIsGfx && !snoopHitM && !hubBusy && !deferEnable)
        |=> dispValid && dispTarget == TGT_HUB)
        else $error("io not forwarded to hub");

    a_inta_hub: assert property (@(posedge clk) disable iff (sys_rst)
        (headBusy && headReq.reqA == REQ_INTA_SPEC && headReq.reqB == REQB_INTA
         && !snoopHitM && !hubBusy && !deferEnable)
        |=> dispValid && dispTarget == TGT_HUB)
        else $error("interrupt acknowledge not sent to hub");

    a_special_pass: assert property (@(posedge clk) disable iff (sys_rst)
        (headBusy && headReq.reqA == REQ_INTA_SPEC
         && headReq.reqB[2:0] == REQB_SPECIAL[2:0] && !snoopHitM)
        |=> dispValid && dispTarget == TGT_SPEC)
        else $error("special cycle not passed on");

    a_defer_track: assert property (@(posedge clk) disable iff (sys_rst)
        (rsp_reg == RSP_DEFER) |-> deferPend_reg)
        else $error("deferred response not tracked");
endmodule

// [rtl/hbd_pkg.sv]
// package: constants and types for the host bus transaction decoder
package hbd_pkg;

    localparam int IOQ_DEPTH = 4;

    localparam logic [4:0] REQ_DEFER_REPLY = 5'h00;
    localparam logic [4:0] REQ_MEM_RDINV   = 5'h02;
    localparam logic [4:0] REQ_MEM_CODE    = 5'h04;
    localparam logic [4:0] REQ_MEM_WB      = 5'h05;
    localparam logic [4:0] REQ_MEM_DATA    = 5'h06;
    localparam logic [4:0] REQ_MEM_WR      = 5'h07;
    localparam logic [4:0] REQ_INTA_SPEC   = 5'h08;
    localparam logic [4:0] REQ_BTM         = 5'h09;
    localparam logic [4:0] REQ_IO_RD       = 5'h10;
    localparam logic [4:0] REQ_IO_WR       = 5'h11;
    localparam logic [4:0] REQB_INTA       = 5'h00;
    localparam logic [4:0] REQB_SPECIAL    = 5'h01;

    localparam logic [1:0] LEN_8    = 2'h0;
    localparam logic [1:0] LEN_16   = 2'h1;
    localparam logic [1:0] LEN_32   = 2'h2;

    localparam logic [2:0] RSP_IDLE   = 3'h0;
    localparam logic [2:0] RSP_RETRY  = 3'h1;
    localparam logic [2:0] RSP_DEFER  = 3'h2;
    localparam logic [2:0] RSP_NODATA = 3'h5;
    localparam logic [2:0] RSP_IWB    = 3'h6;
    localparam logic [2:0] RSP_NORMAL = 3'h7;

    typedef enum logic [5:0] {
        TGT_NONE  = 6'h01,
        TGT_DRAM  = 6'h02,
        TGT_HUB   = 6'h04,
        TGT_CFG   = 6'h08,
        TGT_GFX   = 6'h10,
        TGT_SPEC  = 6'h20
    } hbd_target_e;

    typedef struct packed {
        logic [4:0]  reqA;
        logic [4:0]  reqB;
        logic [31:0] addr;
        logic [7:0]  byteEn;
        logic        locked;
    } hbd_req_s;

    typedef struct packed {
        hbd_target_e target;
        logic        isRead;
        logic        isWrite;
        logic        zeroLen;
        logic        dropData;
        logic        noRetry;
        logic        deferOk;
        logic [5:0]  byteCount;
    } hbd_dec_s;

endpackage

// [rtl/hbd_decode.sv]
// combinational request decoder: target, direction, length
module hbd_decode
    import hbd_pkg::*;
(
    input  wire hbd_req_s req,
    input  wire logic     memIsDram,
    input  wire logic     memIsGfx,
    input  wire logic     ioIsCfg,
    input  wire logic     ioIsGfx,
    output hbd_dec_s      dec
);
    logic [1:0] lenCode;
    assign lenCode = req.reqB[1:0];

    function automatic logic [5:0] len_bytes(input logic [1:0] code, input logic [7:0] be);
        logic [5:0] n;
        n = '0;
        unique case (code)
            LEN_8:   for (int i = 0; i < 8; i++) n = n + {5'h00, be[i]};
            LEN_16:  n = 6'h10;
            LEN_32:  n = 6'h20;
            default: n = 6'h00;
        endcase
        return n;
    endfunction

    always_comb begin
        dec = '0;
        dec.target = TGT_NONE;
        dec.byteCount = len_bytes(lenCode, req.byteEn);
        unique case (req.reqA)
            REQ_INTA_SPEC: begin
                if (req.reqB == REQB_INTA) begin
                    dec.target = TGT_HUB;
                    dec.isRead = 1'b1;
                    dec.deferOk = 1'b1;
                end else if (req.reqB[2:0] == REQB_SPECIAL[2:0]) begin
                    dec.target = TGT_SPEC;
                end
            end
            REQ_BTM: begin
                if (req.reqB == 5'h00) begin
                    dec.target = TGT_NONE;
                    dec.dropData = 1'b1;
                end
            end
            REQ_IO_RD, REQ_IO_WR: begin
                dec.isRead = (req.reqA == REQ_IO_RD);
                dec.isWrite = (req.reqA == REQ_IO_WR);
                if (ioIsCfg) begin
                    dec.target = TGT_CFG;
                end else if (ioIsGfx) begin
                    dec.target = TGT_GFX;
                    dec.deferOk = 1'b1;
                end else begin
                    dec.target = TGT_HUB;
                    dec.deferOk = 1'b1;
                end
            end
            REQ_MEM_RDINV, REQ_MEM_CODE, REQ_MEM_DATA, REQ_MEM_WR: begin
                dec.isRead = (req.reqA != REQ_MEM_WR);
                dec.isWrite = (req.reqA == REQ_MEM_WR);
                if (memIsGfx) begin
                    dec.target = TGT_GFX;
                    dec.deferOk = dec.isRead;
                end else if (memIsDram) begin
                    dec.target = TGT_DRAM;
                end else begin
                    dec.target = TGT_HUB;
                    dec.deferOk = dec.isRead;
                end
            end
            REQ_MEM_WB: begin
                dec.isWrite = 1'b1;
                dec.target = TGT_DRAM;
                dec.noRetry = 1'b1;
            end
            default: dec.target = TGT_NONE;
        endcase
        dec.zeroLen = dec.isRead && (dec.byteCount == 6'h00);
    end
endmodule

// [verif/hbd_cpu_agent.sv]
// processor bus agent model: issues pipelined requests to the decoder
module hbd_cpu_agent
    import hbd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reqReady,
    output logic             reqValid,
    output logic [4:0]       codeA,
    output logic [4:0]       codeB,
    output logic [31:0]      addr,
    output logic [7:0]       byteEn,
    output logic             locked
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reqValid = 1'b0;
        codeA    = 5'h00;
        codeB    = 5'h00;
        addr     = 32'h0;
        byteEn   = 8'h00;
        locked   = 1'b0;
    end

    // released lines show the inverse of their last value
    task automatic drop();
        reqValid = 1'b0;
        codeA    = ~codeA;
        codeB    = ~codeB;
        addr     = ~addr;
        byteEn   = ~byteEn;
        locked   = ~locked;
    endtask

    // request held until the edge that takes it
    task automatic send(input int gap, input logic [4:0] a, input logic [4:0] b,
                        input logic [31:0] ad, input logic [7:0] be, input logic lk);
        logic [4:0] bb;
        logic [7:0] e;
        bb = b;
        e  = be;
        if (a[4] || a[4:3] == 2'h0) begin
            bb[4:3] = 2'h0;
            if (bb[1:0] == 2'h3) bb[1:0] = LEN_32;
            if (bb[1:0] != LEN_8) e = 8'hff;
        end
        @(negedge clk);
        if (gap > 0) begin
            drop();
            repeat (gap) @(negedge clk);
        end
        reqValid = 1'b1;
        codeA    = a;
        codeB    = bb;
        addr     = ad;
        byteEn   = e;
        locked   = lk;
        while (reqReady !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask
endmodule

// [verif/host_bus_transaction_decoder_test.sv]
// self-checking bench for the host bus transaction decoder
module host_bus_transaction_decoder_test import hbd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, sys_rst, reqValid, reqReady, reqLocked, dispValid, dispDone, dispDrop;
    logic        memIsDram, memIsGfx, ioIsCfg, ioIsGfx, snoopHitM, hubBusy, deferEnable;
    logic        deferDone, defValid, deferReplyTaken;
    logic [4:0]  codeA, codeB, defCode;
    logic [31:0] reqAddr, ha, rv;
    logic [7:0]  be;
    logic [5:0]  dispBytes;
    logic [2:0]  rsp;
    logic [3:0]  er;
    logic [44:0] de;
    hbd_target_e dispTarget;
    hbd_req_s    dispReq;
    int          mismatches, checks, seed, doneDelay;
    logic [3:0]  rspQ[$];
    logic [44:0] dispQ[$];
    logic [31:0] headQ[$];

    hbd_cpu_agent u_cpu (.clk(clk), .reqReady(reqReady), .reqValid(reqValid), .codeA(codeA),
        .codeB(codeB), .addr(reqAddr), .byteEn(be), .locked(reqLocked));

    hbd_top #(.DEPTH(4)) u_dut (.clk(clk), .sys_rst(sys_rst), .reqValid(reqValid),
        .request_code_phase_a(codeA), .request_code_phase_b(codeB), .reqAddr(reqAddr),
        .byte_enable_lines(be), .reqLocked(reqLocked), .reqReady(reqReady),
        .memIsDram(memIsDram), .memIsGfx(memIsGfx), .ioIsCfg(ioIsCfg), .ioIsGfx(ioIsGfx),
        .snoopHitM(snoopHitM), .hubBusy(hubBusy), .deferEnable(deferEnable),
        .dispValid(dispValid), .dispTarget(dispTarget), .dispReq(dispReq),
        .dispBytes(dispBytes), .dispDropData(dispDrop), .dispDone(dispDone),
        .deferDone(deferDone), .deferReplyValid(defValid), .deferReplyCode(defCode),
        .deferReplyTaken(deferReplyTaken), .response_code_bit2(rsp[2]),
        .response_code_bit1(rsp[1]), .response_code_bit0(rsp[0]));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic note(input logic ok, input logic [44:0] g, input logic [44:0] e);
        checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // drop flag above the three response bits
    task automatic cmp_rsp(input logic [3:0] g, input logic [3:0] e);
        note(g === e, {41'h0, g}, {41'h0, e});
    endtask
    task automatic cmp_disp(input logic [44:0] g, input logic [44:0] e);
        note(g === e, g, e);
    endtask
    task automatic cmp_bit(input logic g, input logic e);
        note(g === e, {44'h0, g}, {44'h0, e});
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // expected outcome noted, then the request issued
    task automatic run(input int gap, input logic [4:0] a, input logic [4:0] b,
                       input logic [31:0] ad, input logic [7:0] e, input logic lk);
        hbd_target_e t;
        logic        rd;
        logic [2:0]  r;
        logic [5:0]  n;
        rd = a inside {REQ_MEM_RDINV, REQ_MEM_CODE, REQ_MEM_DATA, REQ_IO_RD} ||
             (a == REQ_INTA_SPEC && b == REQB_INTA);
        n  = b[1:0] == LEN_16 ? 6'd16 : b[1:0] == LEN_32 ? 6'd32 : 6'($countones(e));
        if (a == REQ_MEM_WB) t = TGT_DRAM;
        else if (a == REQ_BTM) t = TGT_NONE;
        else if (a == REQ_INTA_SPEC) t = b == REQB_INTA ? TGT_HUB : TGT_SPEC;
        else if (a[4]) t = ad[15:0] == 16'h0cf8 ? TGT_CFG : ad[15:12] == 4'h3 ? TGT_GFX : TGT_HUB;
        else t = !ad[31] ? TGT_DRAM : ad[30] ? TGT_GFX : TGT_HUB;
        if (snoopHitM) r = RSP_IWB;
        else if (hubBusy && a != REQ_MEM_WB && (t == TGT_HUB || (t == TGT_DRAM && lk && rd)))
            r = RSP_RETRY;
        else if (deferEnable && t inside {TGT_HUB, TGT_GFX} && (rd || a == REQ_IO_WR))
            r = RSP_DEFER;
        else if (t == TGT_NONE) r = RSP_NODATA;
        else begin
            r = rd ? RSP_NORMAL : RSP_NODATA;
            dispQ.push_back({a[4] | ~a[3], (a[4] | ~a[3]) ? n : 6'h0, t, ad});
        end
        rspQ.push_back({(a == REQ_BTM && b == 5'h00), r});
        u_cpu.send(gap, a, b, ad, e, lk);
        headQ.push_back(ad);
    endtask

    task automatic settle();
        @(negedge clk);
        u_cpu.drop();
        for (int i = 0; i < 300 && (rspQ.size() || dispQ.size()); i++) @(negedge clk);
        cmp_bit(rspQ.size() == 0 && dispQ.size() == 0, 1'b1);
    endtask

    task automatic one(input logic [4:0] a, input logic [4:0] b, input logic [31:0] ad,
                       input logic lk, input logic sn, input logic bz, input logic df);
        snoopHitM   = sn;
        hubBusy     = bz;
        deferEnable = df;
        rv = $random(seed);
        run(0, a, b, ad, rv[7:0] | 8'h01, lk);
        settle();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #500_000;
        mismatches++;
        report_and_stop();
    end

    // response monitor; head address drives the decode inputs
    always @(negedge clk) begin
        if (!sys_rst && rsp !== RSP_IDLE) begin
            er = rspQ.size() ? rspQ.pop_front() : 4'hx;
            cmp_rsp({dispDrop, rsp}, er);
            if (headQ.size()) void'(headQ.pop_front());
        end
        ha        = headQ.size() ? headQ[0] : 32'h0;
        memIsDram = !ha[31];
        memIsGfx  = ha[31] & ha[30];
        ioIsCfg   = ha[15:0] == 16'h0cf8;
        ioIsGfx   = ha[15:12] == 4'h3;
    end

    // target side: checks each dispatch, then finishes it
    always @(negedge clk) begin
        if (!sys_rst && dispValid !== 1'b0) begin
            de = dispQ.size() ? dispQ.pop_front() : 45'hx;
            cmp_disp({de[44], de[44] ? dispBytes : 6'h0, dispTarget, dispReq.addr}, de);
            repeat (doneDelay) @(negedge clk);
            dispDone = 1'b1;
            @(negedge clk);
            dispDone = 1'b0;
        end
    end

    initial begin
        seed = 32'h67cb;
        doneDelay = 1;
        {sys_rst, dispDone, deferDone, deferReplyTaken} = 4'h8;
        {snoopHitM, hubBusy, deferEnable} = 3'h0;
        repeat (4) @(negedge clk);
        cmp_bit(reqReady, 1'b1);
        cmp_bit(dispTarget === TGT_NONE, 1'b1);
        cmp_rsp({dispDrop, rsp}, {1'b0, RSP_IDLE});
        sys_rst = 1'b0;
        one(REQ_MEM_DATA, 5'h00, 32'h0000_1000, 0, 0, 0, 0);
        one(REQ_MEM_CODE, 5'h01, 32'h8000_0000, 0, 0, 0, 0);
        one(REQ_MEM_RDINV, 5'h02, 32'hc000_0040, 0, 0, 0, 0);
        one(REQ_MEM_WB, 5'h02, 32'h8000_0000, 1, 0, 1, 0);
        one(REQ_MEM_WR, 5'h00, 32'h8000_0100, 0, 0, 1, 0);
        one(REQ_MEM_WR, 5'h01, 32'h0000_0200, 0, 0, 0, 0);
        one(REQ_MEM_DATA, 5'h00, 32'h0000_0300, 1, 0, 1, 0);
        one(REQ_IO_RD, 5'h00, 32'h0000_0060, 0, 0, 0, 0);
        one(REQ_IO_WR, 5'h00, 32'h0000_0cf8, 0, 0, 0, 0);
        one(REQ_IO_WR, 5'h00, 32'h0000_0080, 0, 0, 0, 0);
        one(REQ_INTA_SPEC, REQB_INTA, 32'h0, 0, 0, 0, 0);
        one(REQ_INTA_SPEC, REQB_SPECIAL, 32'h0, 0, 0, 0, 0);
        one(REQ_BTM, 5'h00, 32'h0000_0400, 0, 0, 0, 0);
        one(REQ_MEM_DATA, 5'h00, 32'h0000_0500, 0, 1, 1, 0);
        one(REQ_IO_RD, 5'h00, 32'h0000_3000, 0, 0, 0, 1);
        deferDone = 1'b1;
        @(negedge clk);
        deferDone = 1'b0;
        for (int i = 0; i < 20 && defValid !== 1'b1; i++) @(negedge clk);
        cmp_bit(defValid, 1'b1);
        cmp_disp({40'h0, defCode}, {40'h0, REQ_DEFER_REPLY});
        deferReplyTaken = 1'b1;
        @(negedge clk);
        deferReplyTaken = 1'b0;
        @(negedge clk);
        cmp_bit(defValid, 1'b0);
        {snoopHitM, hubBusy, deferEnable} = 3'h0;
        doneDelay = 12;
        for (int i = 0; i < 24; i++) begin
            if (i == 4) begin
                @(negedge clk);
                cmp_bit(reqReady, 1'b0);
                doneDelay = 2;
            end
            rv = $random(seed);
            run(i < 4 ? 0 : int'(rv[9:8]), rv[1] ? (rv[0] ? REQ_MEM_WR : REQ_MEM_DATA) :
                (rv[0] ? REQ_MEM_CODE : REQ_MEM_RDINV), {3'h0, rv[3:2] % 2'h3},
                {rv[31:30], 18'h0, rv[11:0]}, rv[23:16] | 8'h80, 1'b0);
        end
        settle();
        report_and_stop();
    end
endmodule
